// *** lit_move_pkg.sv ***
package lit_move_pkg;

	// ----------------------------------------------------------------
	// instruction encodings (14-bit words)
	// ----------------------------------------------------------------
	localparam int          INSTR_W           = 14;
	localparam logic [13:0] OPC_LIT_PAGE_MASK = 14'h3F80;
	localparam logic [13:0] OPC_LIT_PAGE      = 14'h3180;
	localparam logic [13:0] OPC_LIT_ACC_MASK  = 14'h3F00;
	localparam logic [13:0] OPC_LIT_ACC       = 14'h3000;
	localparam logic [13:0] OPC_ST_DIR_MASK   = 14'h3F80;
	localparam logic [13:0] OPC_ST_DIR        = 14'h0080;
	localparam logic [13:0] OPC_ST_IND_MASK   = 14'h3FF8;
	localparam logic [13:0] OPC_ST_IND        = 14'h0018;
	localparam logic [13:0] OPC_ST_REL_MASK   = 14'h3F80;
	localparam logic [13:0] OPC_ST_REL        = 14'h3F80;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int PTR_SEL_BIT_IND = 2;
	localparam int PTR_SEL_BIT_REL = 6;
	localparam int MODE_LSB        = 0;
	localparam int OFFSET_MSB      = 5;

	// ----------------------------------------------------------------
	// direct addresses of the two indirect access locations
	// ----------------------------------------------------------------
	localparam logic [6:0] ADDR_INDIRECT0 = 7'h00;
	localparam logic [6:0] ADDR_INDIRECT1 = 7'h01;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [6:0]  RST_PC_HIGH = 7'h00;
	localparam logic [7:0]  RST_ACC     = 8'h00;
	localparam logic [15:0] RST_PTR     = 16'h0000;

	// pointer update modes
	typedef enum logic [1:0] {
		MODE_PRE_INC  = 2'b00,
		MODE_PRE_DEC  = 2'b01,
		MODE_POST_INC = 2'b10,
		MODE_POST_DEC = 2'b11
	} pointer_update_mode_e;

endpackage

// *** literal_and_indirect_move_ops.sv ***
`timescale 1ns/100ps

// What this block does
// - load_literal_page_latch puts its 7-bit literal into the pc high latch, no flags touched.
// - load_literal_accumulator puts its 8-bit literal into the accumulator, no flags touched.
// - store_accumulator_direct writes the accumulator to the 7-bit addressed file register.
// - a direct access to an indirect access location goes to the address in its pointer.
// - mode 00 pre-increments and mode 01 pre-decrements, the new pointer being the address.
// - mode 10 writes at the pointer then increments, mode 11 writes then decrements.
// - the relative form writes at pointer plus a signed offset of -32..31, pointer kept.
// - pointers are 16 bits wide and wrap modulo 2^16 on increment and decrement.
// - pointer updates by the indirect store never change any status flag.
module literal_and_indirect_move_ops
	import lit_move_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	// instruction from decode
	input  wire logic        i_instr_valid,
	input  wire logic [13:0] i_instr,
	// bank base for direct addresses
	input  wire logic [15:0] i_bank_base,
	// pointer loads from the rest of the core
	input  wire logic        i_ptr_load,
	input  wire logic        i_ptr_load_sel,
	input  wire logic [15:0] i_ptr_load_data,
	// data memory write port
	output logic             o_mem_we,
	output logic [15:0]      o_mem_addr,
	output logic [7:0]       o_mem_wdata,
	// architectural state
	output logic [6:0]       o_pc_high_latch,
	output logic [7:0]       o_accumulator,
	output logic [15:0]      o_indirect_pointer0,
	output logic [15:0]      o_indirect_pointer1,
	// status flags are never written by these instructions
	output logic             o_status_we
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// 16-bit step; the add is cut to 16 bits so wrap is natural
	function automatic logic [15:0] ptr_step(input logic [15:0] p, input logic dec);
		ptr_step = dec ? 16'(p - 16'h0001) : 16'(p + 16'h0001);
	endfunction

	// opcode compare under a mask; the masked-out bits are the operand fields
	function automatic logic match(input logic [13:0] w, input logic [13:0] m,
		input logic [13:0] v);
		match = ((w & m) == v);
	endfunction

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic                 is_page;
	logic                 is_acc;
	logic                 is_dir;
	logic                 is_ind;
	logic                 is_rel;
	logic                 dir_is_indirect;
	logic                 sel;
	pointer_update_mode_e mode;
	logic [15:0]          sel_ptr;
	logic [15:0]          offset_ext;

	logic [6:0]  pc_high_ff;
	logic [7:0]  acc_ff;
	logic [15:0] ptr0_ff;
	logic [15:0] ptr1_ff;
	logic [15:0] nxt_ptr;
	logic        nxt_ptr_we;
	logic        nxt_mem_we;
	logic [15:0] nxt_mem_addr;
	logic        mem_we_ff;
	logic [15:0] mem_addr_ff;
	logic [7:0]  mem_wdata_ff;

	// encodings are exact, so a word with stray bits set simply is not decoded here
	assign is_page = i_instr_valid && match(i_instr, OPC_LIT_PAGE_MASK, OPC_LIT_PAGE);
	assign is_acc  = i_instr_valid && match(i_instr, OPC_LIT_ACC_MASK, OPC_LIT_ACC);
	assign is_dir  = i_instr_valid && match(i_instr, OPC_ST_DIR_MASK, OPC_ST_DIR);
	assign is_ind  = i_instr_valid && match(i_instr, OPC_ST_IND_MASK, OPC_ST_IND);
	assign is_rel  = i_instr_valid && match(i_instr, OPC_ST_REL_MASK, OPC_ST_REL);

	// direct addresses 00 and 01 are the two indirect access locations
	assign dir_is_indirect = (i_instr[6:1] == ADDR_INDIRECT0[6:1]);
	assign mode            = pointer_update_mode_e'(i_instr[MODE_LSB +: 2]);

	// pointer select per instruction form
	always_comb begin
		if (is_rel) begin
			sel = i_instr[PTR_SEL_BIT_REL];
		end else if (is_ind) begin
			sel = i_instr[PTR_SEL_BIT_IND];
		end else begin
			sel = i_instr[0];
		end
	end

	// the offset is sign extended, so a negative offset reaches below the pointer
	assign sel_ptr    = sel ? ptr1_ff : ptr0_ff;
	assign offset_ext = {{10{i_instr[OFFSET_MSB]}}, i_instr[OFFSET_MSB:0]};

	// ----------------------------------------------------------------
	// address and pointer update
	// ----------------------------------------------------------------
	// one write per store; the address is formed here and registered below,
	// so the memory sees it in the cycle after the edge that takes the word
	always_comb begin
		nxt_mem_we   = 1'b0;
		nxt_mem_addr = 16'h0000;
		nxt_ptr      = sel_ptr;
		nxt_ptr_we   = 1'b0;
		if (is_dir) begin
			nxt_mem_we = 1'b1;
			if (dir_is_indirect) begin
				nxt_mem_addr = sel_ptr;
			end else begin
				nxt_mem_addr = {i_bank_base[15:7], i_instr[6:0]};
			end
		end else if (is_ind) begin
			nxt_mem_we = 1'b1;
			nxt_ptr_we = 1'b1;
			unique case (mode)
				MODE_PRE_INC: begin
					nxt_ptr      = ptr_step(sel_ptr, 1'b0);
					nxt_mem_addr = nxt_ptr;
				end
				MODE_PRE_DEC: begin
					nxt_ptr      = ptr_step(sel_ptr, 1'b1);
					nxt_mem_addr = nxt_ptr;
				end
				MODE_POST_INC: begin
					nxt_mem_addr = sel_ptr;
					nxt_ptr      = ptr_step(sel_ptr, 1'b0);
				end
				MODE_POST_DEC: begin
					nxt_mem_addr = sel_ptr;
					nxt_ptr      = ptr_step(sel_ptr, 1'b1);
				end
			endcase
		end else if (is_rel) begin
			nxt_mem_we   = 1'b1;
			nxt_mem_addr = 16'(sel_ptr + offset_ext);
		end
	end

	// ----------------------------------------------------------------
	// architectural registers
	// ----------------------------------------------------------------
	// page latch load
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			pc_high_ff <= RST_PC_HIGH;
		end else if (is_page) begin
			pc_high_ff <= i_instr[6:0];
		end
	end

	// accumulator load
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			acc_ff <= RST_ACC;
		end else if (is_acc) begin
			acc_ff <= i_instr[7:0];
		end
	end

	// pointers; an instruction update wins over a core load of the same pointer
	// because the store's address was already taken from the old value
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ptr0_ff <= RST_PTR;
			ptr1_ff <= RST_PTR;
		end else begin
			if (nxt_ptr_we && !sel) begin
				ptr0_ff <= nxt_ptr;
			end else if (i_ptr_load && !i_ptr_load_sel) begin
				ptr0_ff <= i_ptr_load_data;
			end
			if (nxt_ptr_we && sel) begin
				ptr1_ff <= nxt_ptr;
			end else if (i_ptr_load && i_ptr_load_sel) begin
				ptr1_ff <= i_ptr_load_data;
			end
		end
	end

	// registered memory write
	// write data is the accumulator before the edge; a literal load and a store
	// never share a cycle, so no bypass from the literal is needed
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			mem_we_ff    <= 1'b0;
			mem_addr_ff  <= 16'h0000;
			mem_wdata_ff <= 8'h00;
		end else begin
			mem_we_ff    <= nxt_mem_we;
			mem_addr_ff  <= nxt_mem_addr;
			mem_wdata_ff <= acc_ff;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_mem_we            = mem_we_ff;
	assign o_mem_addr          = mem_addr_ff;
	assign o_mem_wdata         = mem_wdata_ff;
	assign o_pc_high_latch     = pc_high_ff;
	assign o_accumulator       = acc_ff;
	assign o_indirect_pointer0 = ptr0_ff;
	assign o_indirect_pointer1 = ptr1_ff;
	// tied low: none of these moves may touch a flag, pointer steps included
	assign o_status_we         = 1'b0;

endmodule // literal_and_indirect_move_ops

// *** lit_move_asserts.sv ***
`timescale 1ns/100ps
module lit_move_asserts
	import lit_move_pkg::*;
(
	// clock, reset, inputs
	input wire logic        i_clk_sys,
	input wire logic        i_rstn,
	input wire logic        i_instr_valid,
	input wire logic [13:0] i_instr,
	input wire logic [15:0] i_bank_base,
	input wire logic        i_ptr_load,
	// outputs
	input wire logic        o_mem_we,
	input wire logic [15:0] o_mem_addr,
	input wire logic [7:0]  o_mem_wdata,
	input wire logic [6:0]  o_pc_high_latch,
	input wire logic [7:0]  o_accumulator,
	input wire logic [15:0] o_indirect_pointer0,
	input wire logic [15:0] o_indirect_pointer1,
	input wire logic        o_status_we
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	// exact decodes; a near miss must not count as a request
	wire        pg  = i_instr_valid && (i_instr & OPC_LIT_PAGE_MASK) == OPC_LIT_PAGE;
	wire        ac  = i_instr_valid && (i_instr & OPC_LIT_ACC_MASK) == OPC_LIT_ACC;
	wire        dr  = i_instr_valid && (i_instr & OPC_ST_DIR_MASK) == OPC_ST_DIR;
	wire        ind = i_instr_valid && (i_instr & OPC_ST_IND_MASK) == OPC_ST_IND;
	wire        rel = i_instr_valid && (i_instr & OPC_ST_REL_MASK) == OPC_ST_REL;
	wire [15:0] pi  = i_instr[PTR_SEL_BIT_IND] ? o_indirect_pointer1 : o_indirect_pointer0;
	wire [15:0] pr  = i_instr[PTR_SEL_BIT_REL] ? o_indirect_pointer1 : o_indirect_pointer0;
	wire [15:0] off = {{10{i_instr[OFFSET_MSB]}}, i_instr[5:0]};

	AST_PAGE: assert property (pg |=> o_pc_high_latch == $past(i_instr[6:0]))
		else $error("page latch load wrong");
	AST_ACC: assert property (ac |=> o_accumulator == $past(i_instr[7:0]))
		else $error("accumulator load wrong");
	AST_DIRECT: assert property (dr && i_instr[6:1] != 6'h00 |=> o_mem_we
		&& o_mem_wdata == $past(o_accumulator)
		&& o_mem_addr == {$past(i_bank_base[15:7]), $past(i_instr[6:0])})
		else $error("direct store wrong");
	AST_INDLOC: assert property (dr && i_instr[6:1] == 6'h00 |=> o_mem_we
		&& o_mem_addr == ($past(i_instr[0]) ? $past(o_indirect_pointer1)
		: $past(o_indirect_pointer0)))
		else $error("indirect location not redirected");
	AST_PREINC: assert property (ind && i_instr[2:0] == 3'b000 |=>
		o_indirect_pointer0 == $past(o_indirect_pointer0) + 16'h0001
		&& o_mem_addr == o_indirect_pointer0) else $error("pre-increment wrong");
	AST_PREDEC: assert property (ind && i_instr[2:0] == 3'b101 |=>
		o_indirect_pointer1 == $past(o_indirect_pointer1) - 16'h0001
		&& o_mem_addr == o_indirect_pointer1) else $error("pre-decrement wrong");
	AST_POST: assert property (ind && i_instr[1] |=> o_mem_addr == $past(pi))
		else $error("post mode address wrong");
	AST_REL: assert property (rel && !i_ptr_load |=> o_mem_we
		&& o_mem_addr == $past(pr) + $past(off)
		&& $stable(o_indirect_pointer0) && $stable(o_indirect_pointer1))
		else $error("relative store wrong");
	AST_OTHER: assert property (ind && !i_ptr_load |=> $past(i_instr[2]) ?
		$stable(o_indirect_pointer0) : $stable(o_indirect_pointer1))
		else $error("unselected pointer moved");
	AST_STATUS: assert property (o_status_we == 1'b0)
		else $error("status write seen");
	AST_POSTUPD: assert property (ind && i_instr[2:1] == 2'b11 |=>
		o_indirect_pointer1 == ($past(i_instr[0]) ? $past(o_indirect_pointer1) - 16'h0001
		: $past(o_indirect_pointer1) + 16'h0001))
		else $error("post mode pointer update wrong");
	AST_WE_ONLY: assert property (!(dr || ind || rel) |=> !o_mem_we)
		else $error("memory write without a store");
endmodule // lit_move_asserts

bind literal_and_indirect_move_ops lit_move_asserts i_chk (.*);

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
	logic        clk, rstn, vld, pld, psel, we, swe;
	logic [13:0] ins;
	logic [15:0] bank, pdat, addr, p0, p1, s, n;
	logic [7:0]  wd, acc;
	logic [6:0]  pch;
	int          failures, n_compared, cyc;

	literal_and_indirect_move_ops i_dut (.i_clk_sys(clk), .i_rstn(rstn), .i_instr_valid(vld),
		.i_instr(ins), .i_bank_base(bank), .i_ptr_load(pld), .i_ptr_load_sel(psel),
		.i_ptr_load_data(pdat), .o_mem_we(we), .o_mem_addr(addr), .o_mem_wdata(wd),
		.o_pc_high_latch(pch), .o_accumulator(acc), .o_indirect_pointer0(p0),
		.o_indirect_pointer1(p1), .o_status_we(swe));

	// clock at 50 MHz
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic summarize();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// one instruction, results settled at the next falling edge
	task automatic run(input logic [13:0] w);
		@(negedge clk);
		vld = 1'b1;
		ins = w;
		@(negedge clk);
		vld = 1'b0;
		chk("status_we", 16'(swe), 16'h0000);
	endtask

	task automatic ld(input logic sel, input logic [15:0] v);
		@(negedge clk);
		pld = 1'b1;
		psel = sel;
		pdat = v;
		@(negedge clk);
		pld = 1'b0;
	endtask

	task automatic t_lit();
		run(14'h31FF);
		chk("pc_high", 16'(pch), 16'h007F);
		run(14'h30A5);
		chk("acc", 16'(acc), 16'h00A5);
		chk("pc_high_kept", 16'(pch), 16'h007F);
	endtask

	task automatic t_dir();
		run(14'h304F);
		bank = 16'h0080;
		run(14'h0085);
		chk("dir_we", 16'(we), 16'h0001);
		chk("dir_addr", addr, 16'h0085);
		chk("dir_data", 16'(wd), 16'h004F);
		@(negedge clk);
		chk("dir_we_end", 16'(we), 16'h0000);
		ld(1'b0, 16'h1234);
		run(14'h0080);
		chk("loc_we", 16'(we), 16'h0001);
		chk("loc_addr", addr, 16'h1234);
		chk("loc_ptr", p0, 16'h1234);
		ld(1'b1, 16'hABCD);
		run(14'h0081);
		chk("loc1_addr", addr, 16'hABCD);
		chk("loc1_ptr", p1, 16'hABCD);
	endtask

	// every update mode on pointer 1, each one crossing the wrap point
	task automatic t_ind();
		for (int m = 0; m < 4; m++) begin
			s = m[0] ? 16'h0000 : 16'hFFFF;
			n = m[0] ? 16'hFFFF : 16'h0000;
			ld(1'b1, s);
			run(14'h001C | 14'(m));
			chk("ind_ptr", p1, n);
			chk("ind_addr", addr, m[1] ? s : n);
			chk("ind_other", p0, 16'h1234);
		end
		run(14'h0018);
		chk("ind_p0", p0, 16'h1235);
	endtask

	task automatic t_rel();
		ld(1'b1, 16'h0000);
		run(14'h3FFF);
		chk("rel_addr", addr, 16'hFFFF);
		chk("rel_ptr", p1, 16'h0000);
		run(14'h3F9F);
		chk("rel_addr2", addr, 16'h1254);
		chk("rel_ptr2", p0, 16'h1235);
	endtask

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			summarize();
		end
	end

	initial begin
		{rstn, vld, pld, psel} = 4'h0;
		ins = 14'h0000;
		bank = 16'h0000;
		pdat = 16'h0000;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		t_lit();
		t_dir();
		t_ind();
		t_rel();
		summarize();
	end
endmodule // tb
